// ---- design/fm_tune_defs.svh ----
// register offsets, reset values and timing counts of the tuner control block
`ifndef FM_TUNE_DEFS_SVH
`define FM_TUNE_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CTRL_OFF      12'h000
`define SEEK_CFG_OFF  12'h004
`define AUDIO_CFG_OFF 12'h008
`define PIN_CFG_OFF   12'h00c
`define STATUS_OFF    12'h010
`define FREQ_OFF      12'h014

// ---------------------------------------------------------------
// register widths and reset values
// ---------------------------------------------------------------
`define CTRL_W          18
`define SEEK_CFG_W      16
`define AUDIO_CFG_W     14
`define PIN_CFG_W       10
`define CTRL_RST        18'h00000
`define SEEK_CFG_RST    16'h0019
`define AUDIO_CFG_RST   14'h0000
`define PIN_CFG_RST     10'h000

// ---------------------------------------------------------------
// pin function codes and band limits in kHz
// ---------------------------------------------------------------
`define PIN_FN_INPUT    2'h0
`define PIN_FN_SPECIAL  2'h1
`define PIN_FN_LOW      2'h2
`define PIN_FN_HIGH     2'h3
`define BAND_LOW_KHZ    17'h128e0
`define BAND_HIGH_KHZ   17'h155cc
`define BAND_MAX_KHZ    17'h1a5e0
`define BAND_JP_MAX_KHZ 17'h15f90

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ          10000000
`define SETTLE_MS       60
`define IRQ_PULSE_MS    5
`define SETTLE_CYC      (`SETTLE_MS * (`CLK_HZ / 1000))
`define IRQ_PULSE_CYC   (`IRQ_PULSE_MS * (`CLK_HZ / 1000))

`endif

// ---- design/fm_tune_pkg.sv ----
// types shared by the tuner control block
package fm_tune_pkg;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_settle = 3'b010,
    st_done   = 3'b100
  } tune_state_t;

  typedef struct packed {
    logic [9:0] station_index;
    logic [1:0] lower_edge_select;
    logic [1:0] channel_step_select;
    logic       wrap_policy;
    logic       direction_up;
    logic       scan_request;
    logic       station_set_request;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] impulse_threshold;
    logic [3:0] quality_threshold;
    logic [7:0] signal_level_threshold;
  } seek_cfg_t;

  typedef struct packed {
    logic       soft_attenuation_disable;
    logic [1:0] soft_attenuation_level;
    logic [1:0] soft_attenuation_rate;
    logic [3:0] volume;
    logic       output_silence_release;
    logic       filter_time_select;
    logic       force_single_output;
    logic [1:0] blend_range;
  } audio_cfg_t;

  typedef struct packed {
    logic [2:0] gp_out;
    logic       done_irq_enable;
    logic [1:0] pin_three_fn;
    logic [1:0] pin_two_fn;
    logic [1:0] pin_one_fn;
  } pin_cfg_t;

  typedef struct packed {
    logic [7:0] signal_level;
    logic [3:0] quality;
    logic [3:0] impulse;
    logic       freq_loop_railed;
    logic       pilot_present;
  } meas_t;

  typedef struct packed {
    logic       mute;
    logic       mono;
    logic       deemph_50us;
    logic [3:0] volume;
    logic [1:0] blend_range;
    logic       soft_att_enable;
    logic       soft_att_force;
    logic [1:0] soft_att_rate;
    logic [1:0] soft_att_level;
  } audio_out_t;

endpackage : fm_tune_pkg

// ---- design/fm_tune_seek_control.sv ----
// tune and seek sequencer, audio settings and pin control behind apb
//
// Summary of operation
// - tuned frequency is step times station index plus lower band edge
// - channel_step_select picks 50, 100 or 200 kHz step
// - ten-bit station_index is the multiplier when a tune starts
// - lower_edge_select puts band bottom at 76 or 87.5 MHz
// - station_set_request starts tune; done flag and signal_level follow
// - host clears station_set_request after done; device then clears done
// - seek steps up or down, stops where level reaches threshold
// - quality and impulse qualifiers, both off after reset
// - wrap_policy low: wrap edges; failure sets flag, returns to start
// - wrap_policy high: stop at band edge and set search_fail_flag
// - seek starts with scan_request, direction_up picks direction
// - readback tracks seek progress; done shows level and channel
// - channel valid after good seek, else unrailed and level reached
// - railed frequency loop forces soft attenuation mute
// - clearing scan_request clears flags after done, aborts before
// - done interrupt drives pin_two low 5 ms when enabled
// - pins selectable: interrupt, stereo indicator or general purpose
// - general purpose pins work regardless of other control bits
// - two_channel_flag, forced mono and blend_range output
// - filter_time_select chooses 50 or 75 us de-emphasis
// - output_silence_release unmutes; four-bit volume setting
// - soft attenuation rate, level and disable settings
`timescale 1ns/1ps
`include "fm_tune_defs.svh"

module fm_tune_seek_control
  import fm_tune_pkg::*;
#(
  parameter int SETTLE_CYCLES    = `SETTLE_CYC,
  parameter int IRQ_PULSE_CYCLES = `IRQ_PULSE_CYC,
  parameter int CNT_W            = 20
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire meas_t       meas,
  output logic      [16:0] tuned_freq_khz,
  output audio_out_t       audio_ctl,
  input  wire logic [2:0]  pin_in,
  output logic      [2:0]  pin_out,
  output logic      [2:0]  pin_oe
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CNT_W))
    $error("SETTLE_CYCLES out of counter range");
  if (IRQ_PULSE_CYCLES < 1 || IRQ_PULSE_CYCLES >= (1 << CNT_W))
    $error("IRQ_PULSE_CYCLES out of counter range");

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    tune_state_t      st;
    ctrl_t            ctrl;
    seek_cfg_t        seek_cfg;
    audio_cfg_t       audio_cfg;
    pin_cfg_t         pin_cfg;
    logic [9:0]       idx;
    logic [9:0]       start_idx;
    logic             is_seek;
    logic             returning;
    logic             done;
    logic             fail;
    logic             seek_ok;
    logic [7:0]       level;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] irq_cnt;
    logic [16:0]      freq;
    audio_out_t       audio;
    logic [2:0]       pout;
    logic [2:0]       poe;
    logic [31:0]      rdata;
  } regs_t;

  regs_t s;
  regs_t n;

  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] IRQ_LOAD    = CNT_W'(IRQ_PULSE_CYCLES);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] step_khz(input logic [1:0] sel);
    case (sel)
      2'h0:    step_khz = 8'hc8;
      2'h1:    step_khz = 8'h64;
      default: step_khz = 8'h32;
    endcase
  endfunction : step_khz

  function automatic logic [16:0] bottom_khz(input logic [1:0] band);
    bottom_khz = (band == 2'h0) ? `BAND_HIGH_KHZ : `BAND_LOW_KHZ;
  endfunction : bottom_khz

  // highest index inside the band; table avoids a divider
  function automatic logic [9:0] max_index(input logic [1:0] sp,
                                           input logic [1:0] band);
    logic [9:0] m;
    m = 10'h000;
    if (band == 2'h0) begin
      m = (sp == 2'h0) ? 10'h066 : (sp == 2'h1) ? 10'h0cd : 10'h19a;
    end else if (band == 2'h2) begin
      m = (sp == 2'h0) ? 10'h046 : (sp == 2'h1) ? 10'h08c : 10'h118;
    end else begin
      m = (sp == 2'h0) ? 10'h0a0 : (sp == 2'h1) ? 10'h140 : 10'h280;
    end
    max_index = m;
  endfunction : max_index

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `CTRL_OFF) || (a == `SEEK_CFG_OFF) ||
                (a == `AUDIO_CFG_OFF) || (a == `PIN_CFG_OFF) ||
                (a == `STATUS_OFF) || (a == `FREQ_OFF);
  endfunction : is_mapped

  // returns {oe, out} for one pin
  function automatic logic [1:0] pin_drive(input logic [1:0] fn,
                                           input logic       sp_oe,
                                           input logic       sp_val);
    case (fn)
      `PIN_FN_SPECIAL: pin_drive = {sp_oe, sp_val};
      `PIN_FN_LOW:     pin_drive = 2'b10;
      `PIN_FN_HIGH:    pin_drive = 2'b11;
      default:         pin_drive = 2'b00;
    endcase
  endfunction : pin_drive

  // ---------------------------------------------------------------
  // combinational terms
  // ---------------------------------------------------------------
  logic [9:0] maxi;
  logic [9:0] nxt;
  logic       at_edge;
  logic       qualified;
  logic       station_index_valid;
  logic       req_held;

  always_comb begin
    maxi = max_index(s.ctrl.channel_step_select, s.ctrl.lower_edge_select);
    if (s.ctrl.direction_up) begin
      at_edge = (s.idx >= maxi);
      nxt     = at_edge ? 10'h000 : s.idx + 10'h001;
    end else begin
      at_edge = (s.idx == 10'h000);
      nxt     = at_edge ? maxi : s.idx - 10'h001;
    end
    // a zero qualifier threshold leaves that detector out
    qualified = (meas.signal_level >=
                 s.seek_cfg.signal_level_threshold) &&
                ((s.seek_cfg.quality_threshold == 4'h0) ||
                 (meas.quality >= s.seek_cfg.quality_threshold)) &&
                ((s.seek_cfg.impulse_threshold == 4'h0) ||
                 (meas.impulse <= s.seek_cfg.impulse_threshold));
    station_index_valid = s.seek_ok ? 1'b1 :
                 (!meas.freq_loop_railed &&
                  (s.level >= s.seek_cfg.signal_level_threshold));
    req_held = s.is_seek ? s.ctrl.scan_request
                         : s.ctrl.station_set_request;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = s;

    // apb writes land on the access cycle only
    if (psel && penable && pwrite) begin
      if (paddr == `CTRL_OFF) begin
        n.ctrl = ctrl_t'(pwdata[`CTRL_W-1:0]);
      end else if (paddr == `SEEK_CFG_OFF) begin
        n.seek_cfg = seek_cfg_t'(pwdata[`SEEK_CFG_W-1:0]);
      end else if (paddr == `AUDIO_CFG_OFF) begin
        n.audio_cfg = audio_cfg_t'(pwdata[`AUDIO_CFG_W-1:0]);
      end else if (paddr == `PIN_CFG_OFF) begin
        n.pin_cfg = pin_cfg_t'(pwdata[`PIN_CFG_W-1:0]);
      end
    end

    // read data is captured in the setup cycle
    if (psel && !penable) begin
      if (paddr == `CTRL_OFF) begin
        n.rdata = {14'h0000, s.ctrl};
      end else if (paddr == `SEEK_CFG_OFF) begin
        n.rdata = {16'h0000, s.seek_cfg};
      end else if (paddr == `AUDIO_CFG_OFF) begin
        n.rdata = {18'h00000, s.audio_cfg};
      end else if (paddr == `PIN_CFG_OFF) begin
        n.rdata = {22'h000000, s.pin_cfg};
      end else if (paddr == `STATUS_OFF) begin
        n.rdata = {3'h0, pin_in, s.idx, s.level, 2'h0,
                   !s.st[0], station_index_valid, meas.freq_loop_railed,
                   s.audio.mono ? 1'b0 : meas.pilot_present,
                   s.fail, s.done};
      end else if (paddr == `FREQ_OFF) begin
        n.rdata = {15'h0000, s.freq};
      end else begin
        n.rdata = 32'h00000000;
      end
    end

    if (s.irq_cnt != '0) begin
      n.irq_cnt = s.irq_cnt - CNT_W'(1);
    end

    case (s.st)
      st_idle: begin
        // a request is only taken here, so repeats during work are dropped
        if (s.ctrl.station_set_request) begin
          n.idx       = s.ctrl.station_index;
          n.is_seek   = 1'b0;
          n.returning = 1'b0;
          n.seek_ok   = 1'b0;
          n.cnt       = SETTLE_LOAD;
          n.st        = st_settle;
        end else if (s.ctrl.scan_request) begin
          n.start_idx = s.idx;
          n.idx       = nxt;
          n.is_seek   = 1'b1;
          n.returning = 1'b0;
          n.seek_ok   = 1'b0;
          n.cnt       = SETTLE_LOAD;
          n.st        = st_settle;
        end
      end
      st_settle: begin
        if (!req_held) begin
          n.st = st_idle;
        end else if (s.cnt != '0) begin
          n.cnt = s.cnt - CNT_W'(1);
        end else begin
          n.level = meas.signal_level;
          if (s.returning || !s.is_seek || qualified) begin
            n.st      = st_done;
            n.done    = 1'b1;
            n.seek_ok = s.is_seek && !s.returning;
          end else if (s.ctrl.wrap_policy && at_edge) begin
            n.st   = st_done;
            n.done = 1'b1;
            n.fail = 1'b1;
          end else if (nxt == s.start_idx) begin
            // whole band seen: retune the channel held before the seek
            n.idx       = s.start_idx;
            n.fail      = 1'b1;
            n.returning = 1'b1;
            n.cnt       = SETTLE_LOAD;
          end else begin
            n.idx = nxt;
            n.cnt = SETTLE_LOAD;
          end
          if (n.done && s.pin_cfg.done_irq_enable &&
              s.pin_cfg.pin_two_fn == `PIN_FN_SPECIAL) begin
            n.irq_cnt = IRQ_LOAD;
          end
        end
      end
      st_done: begin
        if (!req_held) begin
          n.done = 1'b0;
          n.fail = 1'b0;
          n.st   = st_idle;
        end
      end
      default: n.st = st_idle;
    endcase

    n.freq = 17'(bottom_khz(s.ctrl.lower_edge_select) +
                 step_khz(s.ctrl.channel_step_select) * s.idx);

    n.audio.mute            = !s.audio_cfg.output_silence_release;
    n.audio.volume          = s.audio_cfg.volume;
    n.audio.mono            = s.audio_cfg.force_single_output;
    n.audio.blend_range     = s.audio_cfg.blend_range;
    n.audio.deemph_50us     = s.audio_cfg.filter_time_select;
    n.audio.soft_att_enable = !s.audio_cfg.soft_attenuation_disable;
    n.audio.soft_att_rate   = s.audio_cfg.soft_attenuation_rate;
    n.audio.soft_att_level  = s.audio_cfg.soft_attenuation_level;
    // rail mute overrides the soft attenuation disable bit
    n.audio.soft_att_force  = meas.freq_loop_railed;

    // pins driven low or high depend on their function field only
    {n.poe[0], n.pout[0]} = pin_drive(s.pin_cfg.pin_one_fn, 1'b0,
                                      s.pin_cfg.gp_out[0]);
    {n.poe[1], n.pout[1]} = pin_drive(s.pin_cfg.pin_two_fn, 1'b1,
                                      s.irq_cnt == '0);
    {n.poe[2], n.pout[2]} = pin_drive(s.pin_cfg.pin_three_fn, 1'b1,
                                      !(meas.pilot_present &&
                                        !s.audio.mono));
    if (s.pin_cfg.pin_one_fn == `PIN_FN_HIGH ||
        s.pin_cfg.pin_one_fn == `PIN_FN_LOW) begin
      n.pout[0] = s.pin_cfg.pin_one_fn[0];
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.st        <= st_idle;
      s.ctrl      <= ctrl_t'(`CTRL_RST);
      s.seek_cfg  <= seek_cfg_t'(`SEEK_CFG_RST);
      s.audio_cfg <= audio_cfg_t'(`AUDIO_CFG_RST);
      s.pin_cfg   <= pin_cfg_t'(`PIN_CFG_RST);
      s.freq      <= `BAND_HIGH_KHZ;
      s.audio     <= '0;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata         = s.rdata;
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && !is_mapped(paddr);
  assign tuned_freq_khz = s.freq;
  assign audio_ctl      = s.audio;
  assign pin_out        = s.pout;
  assign pin_oe         = s.poe;

endmodule : fm_tune_seek_control

// ---- tb/fm_meas_model.sv ----
// receiver model: measurement report for whatever channel is tuned
`timescale 1ns/1ps

module fm_meas_model
  import fm_tune_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [16:0] tuned_freq_khz,
  input  wire logic [16:0] sta,
  input  wire logic [16:0] rail,
  output meas_t            meas
);
  logic on_sta;

  assign on_sta = tuned_freq_khz == sta || tuned_freq_khz == rail;

  // off-station level moves with the channel, so a stale sample shows up
  always_ff @(posedge pclk) begin
    meas.signal_level     <= on_sta ? 8'hc8 : {3'h1, tuned_freq_khz[4:0]};
    meas.quality          <= 4'h9;
    meas.impulse          <= 4'h2;
    meas.freq_loop_railed <= tuned_freq_khz == rail;
    meas.pilot_present    <= on_sta;
  end
endmodule : fm_meas_model

// ---- tb/fm_tune_seek_control_chk.sv ----
// port assertions of the tuner control block, bound at the foot
`timescale 1ns/1ps
`include "fm_tune_defs.svh"

module fm_tune_seek_control_chk
  import fm_tune_pkg::*;
#(
  parameter int SETTLE_CYCLES    = 8,
  parameter int IRQ_PULSE_CYCLES = 5
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire meas_t       meas,
  input wire logic [16:0] tuned_freq_khz,
  input wire audio_out_t  audio_ctl,
  input wire logic [2:0]  pin_in,
  input wire logic [2:0]  pin_out,
  input wire logic [2:0]  pin_oe
);
  logic        wr;
  pin_cfg_t    pc;
  logic [31:0] lo_cnt;

  assign wr = psel && penable && pwrite && pready;

  // ---------------------------------------------------------------
  // shadow of the pin setup and length of the low pulse on pin_two
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc     <= '0;
      lo_cnt <= '0;
    end else begin
      if (wr && paddr == `PIN_CFG_OFF) begin
        pc <= pwdata[9:0];
      end
      lo_cnt <= (pin_oe[1] && !pin_out[1] && pc.pin_two_fn == 2'h1) ?
                lo_cnt + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_audio_fields: assert property (wr && paddr == `AUDIO_CFG_OFF
    |=> ##1 audio_ctl.volume == $past(pwdata[8:5], 2)
    && audio_ctl.mono == $past(pwdata[2], 2)
    && audio_ctl.deemph_50us == $past(pwdata[3], 2)
    && audio_ctl.blend_range == $past(pwdata[1:0], 2))
    else $error("audio fields wrong");
  a_mute_release: assert property (wr && paddr == `AUDIO_CFG_OFF
    |=> ##1 audio_ctl.mute == !$past(pwdata[4], 2))
    else $error("mute wrong");
  a_soft_att: assert property (wr && paddr == `AUDIO_CFG_OFF |=> ##1
    audio_ctl.soft_att_rate == $past(pwdata[10:9], 2)
    && audio_ctl.soft_att_level == $past(pwdata[12:11], 2)
    && audio_ctl.soft_att_enable == !$past(pwdata[13], 2))
    else $error("soft attenuation wrong");
  a_pin_one: assert property (pin_oe[0] == $past(pc.pin_one_fn[1])
    && (!pin_oe[0] || pin_out[0] == $past(pc.pin_one_fn[0])))
    else $error("pin one drive wrong");
  a_pin_three: assert property ($past(pc.pin_three_fn[1]) |-> pin_oe[2]
    && pin_out[2] == $past(pc.pin_three_fn[0]))
    else $error("pin three drive wrong");
  a_irq_width: assert property ($rose(pin_out[1]) && $past(pin_oe[1])
    && $past(pc.pin_two_fn) == 2'h1 |-> lo_cnt == IRQ_PULSE_CYCLES)
    else $error("pulse length wrong");
  a_irq_bound: assert property (lo_cnt <= IRQ_PULSE_CYCLES)
    else $error("pulse too long");
  a_freq_band: assert property (tuned_freq_khz >= `BAND_LOW_KHZ
    && tuned_freq_khz <= `BAND_MAX_KHZ)
    else $error("frequency off band");
  a_freq_grid: assert property (tuned_freq_khz % 17'h32 == 17'h0)
    else $error("frequency off grid");
  a_unmapped_err: assert property (psel && penable && paddr > `FREQ_OFF
    |-> pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (psel && penable && paddr inside {`CTRL_OFF,
    `SEEK_CFG_OFF, `AUDIO_CFG_OFF, `PIN_CFG_OFF, `STATUS_OFF, `FREQ_OFF}
    |-> !pslverr)
    else $error("error on mapped");
endmodule : fm_tune_seek_control_chk

bind fm_tune_seek_control fm_tune_seek_control_chk #(
  .SETTLE_CYCLES(SETTLE_CYCLES), .IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)
) fm_tune_seek_control_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .meas(meas),
  .tuned_freq_khz(tuned_freq_khz), .audio_ctl(audio_ctl),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
);

// ---- tb/fm_tune_seek_control_tb.sv ----
// self-checking bench for the tuner control block with a receiver model
`timescale 1ns/1ps
`include "fm_tune_defs.svh"

module fm_tune_seek_control_tb;
  import fm_tune_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, stat, lfsr;
  logic [16:0] tuned_freq_khz, sta, rail;
  logic [2:0]  pin_in, pin_out, pin_oe;
  logic [1:0]  sp, bd;
  logic [9:0]  ix;
  meas_t       meas;
  audio_out_t  audio_ctl;
  int          n_fail, n_tests;

  fm_tune_seek_control #(.SETTLE_CYCLES(8), .IRQ_PULSE_CYCLES(5))
  fm_tune_seek_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas),
    .tuned_freq_khz(tuned_freq_khz), .audio_ctl(audio_ctl),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  fm_meas_model fm_meas_model_inst (.pclk(pclk),
    .tuned_freq_khz(tuned_freq_khz), .sta(sta), .rail(rail), .meas(meas));

  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand

  function automatic logic [16:0] f_of(input logic [9:0] i);
    logic [16:0] st;
    st = sp == 2'h0 ? 17'h000c8 : sp == 2'h1 ? 17'h00064 : 17'h00032;
    return (bd == 2'h0 ? `BAND_HIGH_KHZ : `BAND_LOW_KHZ) + st * i;
  endfunction : f_of

  function automatic logic [31:0] cw(input logic [9:0] i, input logic [3:0] m);
    return {14'h0, i, bd, sp, m};
  endfunction : cw

  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ---------------------------------------------------------------
  // bus cycles: held until pready is seen high at a rising edge
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      stop_test();
    end
  endtask : apb

  task automatic poll(input logic [31:0] mask, input logic [31:0] want);
    int k = 0;
    do begin
      apb(1'b0, `STATUS_OFF, 32'h0);
      k++;
    end while ((rd & mask) !== want && k < 4000);
    if (k >= 4000) begin
      n_fail++;
      stop_test();
    end
  endtask : poll

  task automatic tune(input logic [9:0] i);
    apb(1'b1, `CTRL_OFF, cw(i, 4'h1));
    poll(32'h1, 32'h1);
    stat = rd;
    apb(1'b0, `FREQ_OFF, 32'h0);
    chk("freq", {15'h0, f_of(i)}, rd);
    apb(1'b1, `CTRL_OFF, cw(i, 4'h0));
    apb(1'b0, `STATUS_OFF, 32'h0);
    chk("done_clear", 32'h0, rd & 32'h1);
  endtask : tune

  // m carries wrap_policy, direction_up and the seek request
  task automatic seek(input logic [3:0] m, input logic [9:0] want,
                      input logic f);
    apb(1'b1, `CTRL_OFF, cw(10'h0, m));
    poll(32'h1, 32'h1);
    chk("seek_fail", {31'h0, f}, {31'h0, rd[1]});
    chk("seek_station_index", {22'h0, want}, {22'h0, rd[25:16]});
    chk("seek_valid", {31'h0, !f}, {31'h0, rd[4]});
    apb(1'b1, `CTRL_OFF, cw(10'h0, 4'h0));
    apb(1'b0, `STATUS_OFF, 32'h0);
    chk("flags_clear", 32'h0, rd & 32'h3);
  endtask : seek

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sta, rail, sp, bd} = '0;
    pin_in = 3'h5;
    lfsr = 32'hf0645c52;
    n_fail = 0;
    n_tests = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SEEK_CFG_OFF, 32'h0);
    chk("seek_cfg_rst", 32'h19, rd);
    apb(1'b0, `FREQ_OFF, 32'h0);
    chk("freq_rst", {15'h0, `BAND_HIGH_KHZ}, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, `SEEK_CFG_OFF, 32'h80);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      apb(1'b1, `AUDIO_CFG_OFF, {18'h0, lfsr[13:0]});
      apb(1'b0, `AUDIO_CFG_OFF, 32'h0);
      chk("audio_rd", {18'h0, lfsr[13:0]}, rd);
    end
    apb(1'b1, `AUDIO_CFG_OFF, 32'h0);
    // every step code against every band floor, four of them on a station
    for (int i = 0; i < 12; i++) begin
      lfsr = next_rand(lfsr);
      sp = i[1:0];
      bd = i[3:2];
      ix = {4'h0, lfsr[5:0]};
      sta <= lfsr[6] ? f_of(ix) : 17'h0;
      pin_in <= lfsr[9:7];
      tune(ix);
      chk("level", lfsr[6] ? 32'hc8 : 32'h20 | ({15'h0, f_of(ix)} & 32'h1f),
          {24'h0, stat[15:8]});
      chk("valid", {31'h0, lfsr[6]}, {31'h0, stat[4]});
      chk("stereo", {31'h0, lfsr[6]}, {31'h0, stat[2]});
      chk("pins", {29'h0, lfsr[9:7]}, {29'h0, stat[28:26]});
    end
    {sp, bd} = 4'h0;
    sta <= f_of(10'hd);
    tune(10'ha);
    seek(4'h6, 10'hd, 1'b0);
    sta <= f_of(10'h64);
    seek(4'h2, 10'h64, 1'b0);
    sta <= 17'h0;
    seek(4'h2, 10'h64, 1'b1);
    chk("return", {15'h0, f_of(10'h64)}, {15'h0, tuned_freq_khz});
    seek(4'he, 10'h66, 1'b1);
    // quality gate above what the receiver reports must pass the station by
    apb(1'b1, `SEEK_CFG_OFF, 32'ha80);
    sta <= f_of(10'h5);
    seek(4'h6, 10'h66, 1'b1);
    apb(1'b1, `SEEK_CFG_OFF, 32'h80);
    apb(1'b1, `CTRL_OFF, cw(10'h0, 4'h6));
    apb(1'b1, `CTRL_OFF, cw(10'h0, 4'h4));
    poll(32'h20, 32'h0);
    chk("abort", 32'h0, rd & 32'h3);
    apb(1'b1, `CTRL_OFF, cw(10'h7, 4'h1));
    poll(32'h1, 32'h1);
    apb(1'b1, `CTRL_OFF, cw(10'h14, 4'h3));
    repeat (6) apb(1'b0, `STATUS_OFF, 32'h0);
    chk("ignore", 32'h21, rd & 32'h21);
    chk("ignore_freq", {15'h0, f_of(10'h7)}, {15'h0, tuned_freq_khz});
    apb(1'b1, `CTRL_OFF, cw(10'h7, 4'h0));
    rail <= f_of(10'h1e);
    tune(10'h1e);
    chk("railed", 32'h8, stat & 32'h18);
    chk("rail_mute", 32'h1, {31'h0, audio_ctl.soft_att_force});
    tune(10'h1f);
    chk("rail_off", 32'h0, {31'h0, audio_ctl.soft_att_force});
    apb(1'b1, `PIN_CFG_OFF, 32'h67);
    tune(10'h20);
    chk("pin_drive", 32'h1, {29'h0, pin_out & 3'h5});
    chk("pin_oe", 32'h7, {29'h0, pin_oe});
    apb(1'b1, `PIN_CFG_OFF, 32'h0);
    repeat (3) @(posedge pclk);
    chk("pin_in_mode", 32'h0, {29'h0, pin_oe});
    stop_test();
  end
endmodule : fm_tune_seek_control_tb
